// *** caf_pkg.sv ***
// caf_pkg: opcode map, state record and memory request records of the
// addressing and program-flow core.
// assumes one core clock; both memories answer within the request cycle.
package caf_pkg;

  // ==========================================================
  // reset values and fixed addresses
  localparam logic [14:0] PC_RESET = 15'h0000;
  localparam logic [7:0] SP_RESET = 8'h6f;
  localparam logic [14:0] TRAP_VECTOR = 15'h00ff;
  localparam logic [14:0] VIS_TABLE = 15'h01e0;
  localparam logic [3:0] REG_PAGE = 4'hf;
  localparam logic [14:0] REL_BIAS = 15'h0020;
  localparam logic [1:0] LEN_ONE = 2'h1;
  localparam logic [1:0] LEN_TWO = 2'h2;
  localparam logic [1:0] LEN_THREE = 2'h3;

  // ==========================================================
  // opcode groups
  localparam logic [2:0] GRP_SPECIAL = 3'h0;  // op[7:5]
  localparam logic [2:0] GRP_CMP = 3'h1;      // op[7:5]
  localparam logic [3:0] GRP_JMP = 4'h4;      // op[7:4]
  localparam logic [3:0] GRP_JSR = 4'h5;
  localparam logic [3:0] GRP_LDB = 4'h6;
  localparam logic [3:0] GRP_BNE = 4'h7;
  localparam logic [1:0] GRP_ALU = 2'h2;      // op[7:6]
  localparam logic [1:0] GRP_REL = 2'h3;

  // operand modes, op[2:0]
  localparam logic [2:0] MODE_IMM = 3'h0;
  localparam logic [2:0] MODE_DIR = 3'h1;
  localparam logic [2:0] MODE_B = 3'h2;
  localparam logic [2:0] MODE_X = 3'h3;
  localparam logic [2:0] MODE_BINC = 3'h4;
  localparam logic [2:0] MODE_BDEC = 3'h5;
  localparam logic [2:0] MODE_XINC = 3'h6;
  localparam logic [2:0] MODE_XDEC = 3'h7;

  // arithmetic/logic functions op[5:3], compare functions op[4:3]
  localparam logic [2:0] ALU_ADD = 3'h0;
  localparam logic [2:0] ALU_ADC = 3'h1;
  localparam logic [2:0] ALU_SUB = 3'h2;
  localparam logic [2:0] ALU_SUBC = 3'h3;
  localparam logic [2:0] ALU_AND = 3'h4;
  localparam logic [2:0] ALU_OR = 3'h5;
  localparam logic [2:0] ALU_XOR = 3'h6;
  localparam logic [2:0] ALU_LD = 3'h7;
  localparam logic [1:0] CMP_EQ = 2'h0;
  localparam logic [1:0] CMP_NE = 2'h1;
  localparam logic [1:0] CMP_GT = 2'h2;
  localparam logic [1:0] CMP_XCH = 2'h3;

  // single opcodes of the special group
  localparam logic [7:0] OP_NOP = 8'h00;
  localparam logic [7:0] OP_TABLE_LOAD_INSTRUCTION = 8'h01;
  localparam logic [7:0] OP_JID = 8'h02;
  localparam logic [7:0] OP_LONG_ABSOLUTE_JUMP = 8'h03;
  localparam logic [7:0] OP_VIS = 8'h04;
  localparam logic [7:0] OP_LONG_SUBROUTINE_CALL = 8'h05;
  localparam logic [7:0] OP_RET = 8'h06;
  localparam logic [7:0] OP_RETURN_AND_SKIP = 8'h07;
  localparam logic [7:0] OP_INTERRUPT_RETURN = 8'h08;
  localparam logic [7:0] OP_TRAP = 8'h09;
  localparam logic [7:0] OP_RRC = 8'h0a;
  localparam logic [7:0] OP_RLC = 8'h0b;
  localparam logic [7:0] OP_SWAP = 8'h0c;
  localparam logic [7:0] OP_CLR = 8'h0d;
  localparam logic [7:0] OP_INC = 8'h0e;
  localparam logic [7:0] OP_DEC = 8'h0f;
  localparam logic [7:0] OP_DECIMAL_CORRECTION = 8'h10;
  localparam logic [7:0] OP_SC = 8'h11;
  localparam logic [7:0] OP_RC = 8'h12;
  localparam logic [7:0] OP_IFC = 8'h13;
  localparam logic [7:0] OP_IFNC = 8'h14;
  localparam logic [7:0] OP_PUSH = 8'h15;
  localparam logic [7:0] OP_POP = 8'h16;
  localparam logic [7:0] OP_CLRPND = 8'h17;
  localparam logic [7:0] OP_AND_IMMEDIATE_SKIP_ZERO = 8'h18;
  localparam logic [7:0] OP_DECREMENT_AND_SKIP = 8'h19;
  localparam logic [7:0] OP_SETBIT = 8'h1a;
  localparam logic [7:0] OP_CLRBIT = 8'h1b;
  localparam logic [7:0] OP_IFBIT = 8'h1c;

  // ==========================================================
  // states and records
  typedef enum logic [3:0] {
    ST_FETCH, ST_BYTE2, ST_BYTE3, ST_EXEC, ST_MEMRD,
    ST_PUSH_HI, ST_POP_LO, ST_PMRD, ST_VIS_LO
  } caf_state_t;

  typedef struct packed {
    logic rd;
    logic [14:0] addr;
  } caf_pm_req_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } caf_dm_req_t;

  typedef struct packed {
    caf_state_t st;
    logic [14:0] pc;
    logic [7:0] a;
    logic [7:0] b;
    logic [7:0] x;
    logic [7:0] sp;
    logic c;
    logic hc;
    logic skip;
    logic swi;
    logic [7:0] ir;
    logic [7:0] b2;
    logic [7:0] b3;
    caf_pm_req_t pm;
    caf_dm_req_t dm;
  } caf_core_t;

  localparam caf_core_t CORE_RESET = '{st: ST_FETCH, pc: PC_RESET,
    a: 8'h00, b: 8'h00, x: 8'h00, sp: SP_RESET, c: 1'b0, hc: 1'b0,
    skip: 1'b0, swi: 1'b0, ir: 8'h00, b2: 8'h00, b3: 8'h00,
    pm: '{rd: 1'b1, addr: PC_RESET},
    dm: '{rd: 1'b0, wr: 1'b0, addr: 8'h00, wdata: 8'h00}};

endpackage

// *** caf_core.sv ***
// caf_core: operand addressing, program counter and flow control of an
// 8-bit core, with its arithmetic, logic, bit and stack instructions.
// assumes program and data memory return read data combinationally from
// the registered address; data memory writes on the edge with wr high.

`timescale 1ns/1ps
`default_nettype none

module caf_core (
  // clock and reset
  input wire logic I_CLK_SYS,
  input wire logic I_RESET_N,
  // program memory
  output var caf_pkg::caf_pm_req_t O_PM_REQ,
  input wire logic [7:0] I_PM_DATA,
  // data memory
  output var caf_pkg::caf_dm_req_t O_DM_REQ,
  input wire logic [7:0] I_DM_RDATA,
  // interrupt vector choice and visible state
  input wire logic [3:0] I_VEC_INDEX,
  output var logic O_SWI_PENDING,
  output var logic [7:0] O_ACC,
  output var logic O_CARRY
);
  import caf_pkg::*;

  caf_core_t r;
  caf_core_t next_r;
  logic [7:0] opnd;
  logic [9:0] alu_res;
  logic [8:0] dc;
  logic [7:0] mptr;
  logic [7:0] bmask;
  logic [14:0] target;

  // ==========================================================
  // helpers
  function automatic logic [1:0] op_len(input logic [7:0] op);
    op_len = LEN_ONE;
    if (op == OP_LONG_ABSOLUTE_JUMP || op == OP_LONG_SUBROUTINE_CALL) begin
      op_len = LEN_THREE;
    end else if (op[7:5] == 3'h2 || op == OP_AND_IMMEDIATE_SKIP_ZERO || op == OP_DECREMENT_AND_SKIP ||
                 op == OP_SETBIT || op == OP_CLRBIT || op == OP_IFBIT) begin
      op_len = LEN_TWO;
    end else if ((op[7:6] == GRP_ALU || op[7:5] == GRP_CMP) &&
                 op[2:1] == 2'h0) begin
      op_len = LEN_TWO;
    end
  endfunction

  // returns {carry, half carry, result}
  function automatic logic [9:0] alu(input logic [2:0] f,
      input logic [7:0] a, input logic [7:0] m, input logic c,
      input logic hc);
    logic [7:0] mm;
    logic ci;
    logic [8:0] s;
    logic [4:0] h;
    mm = (f == ALU_SUB || f == ALU_SUBC) ? ~m : m;
    ci = (f == ALU_ADC || f == ALU_SUBC) ? c : (f == ALU_SUB);
    s = {1'b0, a} + {1'b0, mm} + {8'h00, ci};
    h = {1'b0, a[3:0]} + {1'b0, mm[3:0]} + {4'h0, ci};
    case (f)
      ALU_AND: alu = {c, hc, a & m};
      ALU_OR: alu = {c, hc, a | m};
      ALU_XOR: alu = {c, hc, a ^ m};
      ALU_LD: alu = {c, hc, m};
      ALU_ADD: alu = {c, hc, s[7:0]};  // plain add leaves the flags
      default: alu = {s[8], h[4], s[7:0]};
    endcase
  endfunction

  // ==========================================================
  // next-state logic
  always_comb begin
    next_r = r;
    next_r.dm.rd = 1'b0;
    next_r.dm.wr = 1'b0;
    opnd = (r.ir[7:5] != GRP_SPECIAL && r.ir[2:0] == MODE_IMM) ?
           r.b2 : I_DM_RDATA;
    alu_res = alu(r.ir[5:3], r.a, opnd, r.c, r.hc);
    bmask = 8'h01 << r.b2[2:0];
    case (r.ir[2:0])
      MODE_DIR: mptr = r.b2;
      MODE_B, MODE_BINC, MODE_BDEC: mptr = r.b;
      default: mptr = r.x;
    endcase
    dc = {1'b0, r.a};
    if (r.hc || r.a[3:0] > 4'h9) begin
      dc = dc + 9'h006;
    end
    if (r.c || r.a > 8'h99) begin
      dc = dc + 9'h060;
    end
    case (r.ir)
      OP_LONG_SUBROUTINE_CALL: target = {r.b2[6:0], r.b3};
      OP_TRAP: target = TRAP_VECTOR;
      default: target = {r.pc[14:12], r.ir[3:0], r.b2};
    endcase

    case (r.st)
      ST_FETCH: begin
        next_r.ir = I_PM_DATA;
        if (r.skip) begin
          // skipped opcode and its operand bytes pass untouched
          next_r.skip = 1'b0;
          next_r.pc = r.pc + {13'h0000, op_len(I_PM_DATA)};
        end else begin
          next_r.pc = r.pc + 15'h0001;
          next_r.st = (op_len(I_PM_DATA) == LEN_ONE) ? ST_EXEC : ST_BYTE2;
        end
      end
      ST_BYTE2: begin
        next_r.b2 = I_PM_DATA;
        next_r.pc = r.pc + 15'h0001;
        next_r.st = (op_len(r.ir) == LEN_THREE) ? ST_BYTE3 : ST_EXEC;
      end
      ST_BYTE3: begin
        next_r.b3 = I_PM_DATA;
        next_r.pc = r.pc + 15'h0001;
        next_r.st = ST_EXEC;
      end
      ST_EXEC: begin
        next_r.st = ST_FETCH;
        if (r.ir[7:6] == GRP_REL) begin
          // a +1 displacement is never coded; software uses a no-op
          next_r.pc = r.pc + {9'h000, r.ir[5:0]} - REL_BIAS;
        end else if (r.ir[7:4] == GRP_JMP) begin
          next_r.pc = {r.pc[14:12], r.ir[3:0], r.b2};
        end else if (r.ir[7:4] == GRP_LDB) begin
          next_r.b = {4'h0, r.ir[3:0]};
        end else if (r.ir[7:4] == GRP_BNE) begin
          next_r.skip = (r.b[3:0] == r.ir[3:0]);
        end else if (r.ir[7:4] == GRP_JSR || r.ir == OP_LONG_SUBROUTINE_CALL ||
                     r.ir == OP_TRAP) begin
          next_r.dm.wr = 1'b1;
          next_r.dm.addr = r.sp;
          next_r.dm.wdata = r.pc[7:0];
          next_r.b3 = {1'b0, r.pc[14:8]};
          next_r.sp = r.sp - 8'h01;
          next_r.pc = target;
          next_r.swi = r.swi | (r.ir == OP_TRAP);
          next_r.st = ST_PUSH_HI;
        end else if (r.ir[7:5] != GRP_SPECIAL) begin
          // alu and compare groups; immediates read no data memory
          next_r.dm.addr = mptr;
          next_r.dm.rd = (r.ir[2:0] != MODE_IMM);
          next_r.st = ST_MEMRD;
        end else begin
          case (r.ir)
            OP_TABLE_LOAD_INSTRUCTION, OP_JID: begin
              // pc itself stays put, which restores the low byte
              next_r.pm.addr = {r.pc[14:8], r.a};
              next_r.st = ST_PMRD;
            end
            OP_LONG_ABSOLUTE_JUMP: next_r.pc = {r.b2[6:0], r.b3};
            OP_VIS: begin
              next_r.pm.addr = VIS_TABLE +
                               {10'h000, I_VEC_INDEX, 1'b0};
              next_r.st = ST_PMRD;
            end
            OP_RET, OP_RETURN_AND_SKIP, OP_INTERRUPT_RETURN, OP_POP: begin
              next_r.sp = r.sp + 8'h01;
              next_r.dm.addr = r.sp + 8'h01;
              next_r.dm.rd = 1'b1;
              next_r.st = ST_MEMRD;
            end
            OP_PUSH: begin
              next_r.dm.wr = 1'b1;
              next_r.dm.addr = r.sp;
              next_r.dm.wdata = r.a;
              next_r.sp = r.sp - 8'h01;
            end
            OP_DECREMENT_AND_SKIP: begin
              next_r.dm.addr = {REG_PAGE, r.b2[3:0]};
              next_r.dm.rd = 1'b1;
              next_r.st = ST_MEMRD;
            end
            OP_SETBIT, OP_CLRBIT, OP_IFBIT: begin
              next_r.dm.addr = r.b;
              next_r.dm.rd = 1'b1;
              next_r.st = ST_MEMRD;
            end
            OP_RRC: {next_r.a, next_r.c} = {r.c, r.a};
            OP_RLC: {next_r.c, next_r.a} = {r.a, r.c};
            OP_SWAP: next_r.a = {r.a[3:0], r.a[7:4]};
            OP_CLR: next_r.a = 8'h00;
            OP_INC: next_r.a = r.a + 8'h01;
            OP_DEC: next_r.a = r.a - 8'h01;
            OP_DECIMAL_CORRECTION: begin
              next_r.a = dc[7:0];
              next_r.c = dc[8] | r.c | (r.a > 8'h99);
            end
            OP_SC: next_r.c = 1'b1;
            OP_RC: next_r.c = 1'b0;
            OP_IFC: next_r.skip = ~r.c;
            OP_IFNC: next_r.skip = r.c;
            OP_CLRPND: next_r.swi = 1'b0;
            OP_AND_IMMEDIATE_SKIP_ZERO: next_r.skip = ((r.a & r.b2) == 8'h00);
            default: ;  // no-op and spare codes touch nothing
          endcase
        end
      end
      ST_MEMRD: begin
        next_r.st = ST_FETCH;
        if (r.ir[7:6] == GRP_ALU) begin
          {next_r.c, next_r.hc, next_r.a} = alu_res;
        end else if (r.ir[7:5] == GRP_CMP) begin
          case (r.ir[4:3])
            CMP_EQ: next_r.skip = (r.a != opnd);
            CMP_NE: next_r.skip = (r.a == opnd);
            CMP_GT: next_r.skip = (r.a <= opnd);
            default: begin
              if (r.ir[2:0] != MODE_IMM) begin
                next_r.a = opnd;
                next_r.dm.wr = 1'b1;
                next_r.dm.addr = r.dm.addr;
                next_r.dm.wdata = r.a;
              end
            end
          endcase
        end else begin
          case (r.ir)
            OP_POP: next_r.a = I_DM_RDATA;
            OP_RET, OP_RETURN_AND_SKIP, OP_INTERRUPT_RETURN: begin
              next_r.pc[14:8] = I_DM_RDATA[6:0];
              next_r.sp = r.sp + 8'h01;
              next_r.dm.addr = r.sp + 8'h01;
              next_r.dm.rd = 1'b1;
              next_r.st = ST_POP_LO;
            end
            OP_DECREMENT_AND_SKIP: begin
              next_r.dm.wr = 1'b1;
              next_r.dm.addr = r.dm.addr;
              next_r.dm.wdata = I_DM_RDATA - 8'h01;
              next_r.skip = (I_DM_RDATA == 8'h01);
            end
            OP_SETBIT, OP_CLRBIT: begin
              next_r.dm.wr = 1'b1;
              next_r.dm.addr = r.dm.addr;
              next_r.dm.wdata = (r.ir == OP_SETBIT) ?
                                (I_DM_RDATA | bmask) : (I_DM_RDATA & ~bmask);
            end
            OP_IFBIT: next_r.skip = ((I_DM_RDATA & bmask) == 8'h00);
            default: ;
          endcase
        end
        // pointer steps only after its access has been made
        if (r.ir[7:5] != GRP_SPECIAL) begin
          case (r.ir[2:0])
            MODE_BINC: next_r.b = r.b + 8'h01;
            MODE_BDEC: next_r.b = r.b - 8'h01;
            MODE_XINC: next_r.x = r.x + 8'h01;
            MODE_XDEC: next_r.x = r.x - 8'h01;
            default: ;
          endcase
        end
      end
      ST_PUSH_HI: begin
        next_r.dm.wr = 1'b1;
        next_r.dm.addr = r.sp;
        next_r.dm.wdata = r.b3;
        next_r.sp = r.sp - 8'h01;
        next_r.st = ST_FETCH;
      end
      ST_POP_LO: begin
        next_r.pc[7:0] = I_DM_RDATA;
        next_r.skip = (r.ir == OP_RETURN_AND_SKIP);
        next_r.st = ST_FETCH;
      end
      ST_PMRD: begin
        next_r.st = ST_FETCH;
        if (r.ir == OP_TABLE_LOAD_INSTRUCTION) begin
          next_r.a = I_PM_DATA;
        end else if (r.ir == OP_JID) begin
          next_r.pc[7:0] = I_PM_DATA;
        end else begin
          next_r.pc[14:8] = I_PM_DATA[6:0];
          next_r.pm.addr = r.pm.addr + 15'h0001;
          next_r.st = ST_VIS_LO;
        end
      end
      ST_VIS_LO: begin
        next_r.pc[7:0] = I_PM_DATA;
        next_r.st = ST_FETCH;
      end
      default: next_r.st = ST_FETCH;
    endcase

    if (next_r.st == ST_FETCH || next_r.st == ST_BYTE2 ||
        next_r.st == ST_BYTE3) begin
      next_r.pm.addr = next_r.pc;
    end
    next_r.pm.rd = (next_r.st == ST_FETCH || next_r.st == ST_BYTE2 ||
                    next_r.st == ST_BYTE3 || next_r.st == ST_PMRD ||
                    next_r.st == ST_VIS_LO);
  end

  // ==========================================================
  // state register and outputs
  always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      r <= CORE_RESET;
    end else begin
      r <= next_r;
    end
  end

  assign O_PM_REQ = r.pm;
  assign O_DM_REQ = r.dm;
  assign O_SWI_PENDING = r.swi;
  assign O_ACC = r.a;
  assign O_CARRY = r.c;

  // ==========================================================
  // checks
  a_ptr_select: assert property (
    @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
    (r.st == ST_EXEC && r.ir[7:6] == GRP_ALU && r.ir[2:0] == MODE_X)
    |=> (O_DM_REQ.rd && O_DM_REQ.addr == $past(r.x)))
    else $error("x-indirect operand not read at pointer x");

  a_ptr_postinc: assert property (
    @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
    (r.st == ST_MEMRD && r.ir[7:5] != GRP_SPECIAL && r.ir[2:0] == MODE_BINC)
    |=> (r.b == $past(r.b) + 8'h01))
    else $error("post-increment did not step pointer b");

  a_short_ldb: assert property (
    @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
    (r.st == ST_EXEC && r.ir[7:4] == GRP_LDB)
    |=> (r.b[7:4] == 4'h0 && r.b[3:0] == $past(r.ir[3:0])))
    else $error("short load of b wrong");

  a_table_keep: assert property (
    @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
    (r.st == ST_EXEC && r.ir == OP_TABLE_LOAD_INSTRUCTION)
    |-> ##1 (O_PM_REQ.addr[7:0] == $past(r.a))
    ##1 (r.a == $past(I_PM_DATA) && r.pc == $past(r.pc, 2)))
    else $error("table load wrong data or pc moved");

  a_rel_target: assert property (
    @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
    (r.st == ST_EXEC && r.ir[7:6] == GRP_REL)
    |=> (r.pc == $past(r.pc) + {9'h000, $past(r.ir[5:0])} - REL_BIAS))
    else $error("relative jump target wrong");

  a_abs_page: assert property (
    @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
    (r.st == ST_EXEC && r.ir[7:4] == GRP_JMP)
    |=> (r.pc[14:12] == $past(r.pc[14:12]) && r.pc[7:0] == $past(r.b2)))
    else $error("absolute jump left its page");

  a_skip_len: assert property (
    @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
    (r.st == ST_FETCH && r.skip && I_PM_DATA[7:6] == GRP_REL)
    |=> (r.st == ST_FETCH && !r.skip && r.pc == $past(r.pc) + 15'h0001))
    else $error("skipped one-byte instruction not passed over");

  a_call_push: assert property (
    @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
    (r.st == ST_EXEC && (r.ir == OP_LONG_SUBROUTINE_CALL || r.ir[7:4] == GRP_JSR))
    |=> (O_DM_REQ.wr && O_DM_REQ.wdata == $past(r.pc[7:0]))
    ##1 (O_DM_REQ.wr && r.pc == $past(target, 2)))
    else $error("call did not push pc before jumping");

  a_decrement_and_skip_page: assert property (
    @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
    (r.st == ST_EXEC && r.ir == OP_DECREMENT_AND_SKIP)
    |=> (O_DM_REQ.rd && O_DM_REQ.addr[7:4] == REG_PAGE) ##1 O_DM_REQ.wr)
    else $error("decrement-and-skip off the register page");

  a_pc_step: assert property (
    @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
    (r.st == ST_BYTE2) |=> (r.pc == $past(r.pc) + 15'h0001))
    else $error("pc did not step on operand fetch");

endmodule // caf_core

`default_nettype wire

// *** caf_mem_model.sv ***
// caf_mem_model: program and data memory on the far side of the core.
// assumes one core clock; reads answer combinationally, writes on the edge.
`timescale 1ns/1ps
`default_nettype none

module caf_mem_model (
  // clock
  input wire logic i_clk_sys,
  // program memory
  input wire caf_pkg::caf_pm_req_t i_pm_req,
  output logic [7:0] o_pm_data,
  // data memory
  input wire caf_pkg::caf_dm_req_t i_dm_req,
  output logic [7:0] o_dm_rdata
);
  import caf_pkg::*;
  // ==========================================================
  // storage
  logic [7:0] rom [0:32767];
  logic [7:0] ram [0:255];

  // idle read lines show inverted bits so a stale value never matches
  assign o_pm_data = i_pm_req.rd ? rom[i_pm_req.addr] : ~rom[i_pm_req.addr];
  assign o_dm_rdata = i_dm_req.rd ? ram[i_dm_req.addr] : ~ram[i_dm_req.addr];

  always @(posedge i_clk_sys) begin
    if (i_dm_req.wr) begin
      ram[i_dm_req.addr] <= i_dm_req.wdata;
    end
  end

  // self-loop fill: a runaway fetch parks instead of wandering
  initial begin
    for (int i = 0; i < 32768; i++) begin
      rom[i] = 8'hdf;
    end
    for (int i = 0; i < 256; i++) begin
      ram[i] = 8'h00;
    end
  end
endmodule // caf_mem_model

`default_nettype wire

// *** cpu_addressing_and_flow_tb_top.sv ***
// testbench: short programs run from reset, results read at the ports and in the data memory.
// assumes caf_core and caf_mem_model; programs end in a self-loop (0xdf).
`timescale 1ns/1ps
`default_nettype none

module cpu_addressing_and_flow_tb_top;
  import caf_pkg::*;
  // ==========================================================
  // signals
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] vec_index = 4'h3;
  caf_pm_req_t pm_req;
  caf_dm_req_t dm_req;
  logic [7:0] pm_data;
  logic [7:0] dm_rdata;
  logic [7:0] acc;
  logic swi;
  logic carry;
  int n_errors = 0;
  int n_tests = 0;
  int cycles = 0;

  always #12.5 clk_sys = ~clk_sys;

  caf_core dut_u (.I_CLK_SYS(clk_sys), .I_RESET_N(reset_n),
    .O_PM_REQ(pm_req), .I_PM_DATA(pm_data), .O_DM_REQ(dm_req),
    .I_DM_RDATA(dm_rdata), .I_VEC_INDEX(vec_index), .O_SWI_PENDING(swi),
    .O_ACC(acc), .O_CARRY(carry));
  caf_mem_model mem_u (.i_clk_sys(clk_sys), .i_pm_req(pm_req),
    .o_pm_data(pm_data), .i_dm_req(dm_req), .o_dm_rdata(dm_rdata));

  // ==========================================================
  // shared tasks
  task automatic final_report();
    $display("errors %0d of %0d checks", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk8(input string what, input logic [7:0] e,
                      input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic load(input int a, input logic [7:0] q[]);
    for (int i = 0; i < q.size(); i++) begin
      mem_u.rom[a + i] = q[i];
    end
  endtask

  // programs never hold a relative jump of +1
  task automatic boot(input logic [7:0] q[]);
    @(posedge clk_sys);
    reset_n <= 1'b0;
    repeat (6) @(posedge clk_sys);
    load(0, q);
    reset_n <= 1'b1;
  endtask

  // wait for the fetch of the parking loop, then let writes land
  task automatic run(input logic [14:0] tgt);
    int k;
    k = 0;
    while (!(pm_req.rd === 1'b1 && pm_req.addr === tgt) && k < 300) begin
      @(posedge clk_sys);
      #1;
      k++;
    end
    n_tests++;
    if (k == 300) begin
      n_errors++;
      $display("ERROR pc expected %h seen %h", tgt, pm_req.addr);
    end
    repeat (3) @(posedge clk_sys);
    #1;
  endtask

  // ==========================================================
  // scenarios
  task automatic s_imm();
    boot('{8'hb8, 8'h5c, 8'hdf});
    run(15'h0002);
    chk8("acc", 8'h5c, acc);
  endtask

  task automatic s_ptr();
    mem_u.ram[5] = 8'h62;
    mem_u.ram[6] = 8'h77;
    boot('{8'hb8, 8'h03, 8'h65, 8'h3c, 8'hba, 8'hdf});
    run(15'h0005);
    chk8("ram5", 8'h03, mem_u.ram[5]);
    chk8("acc", 8'h77, acc);
    mem_u.ram[0] = 8'h4b;
    mem_u.ram[1] = 8'h96;
    boot('{8'hbe, 8'hbb, 8'hdf});
    run(15'h0002);
    chk8("acc_x", 8'h96, acc);
  endtask

  task automatic s_table_load_instruction();
    load(15'h001f, '{8'h25});
    boot('{8'hb8, 8'h1f, 8'h01, 8'hdf});
    run(15'h0003);
    chk8("acc", 8'h25, acc);
  endtask

  task automatic s_jumps();
    load(15'h0125, '{8'he9});
    boot('{8'h41, 8'h25});
    run(15'h012f);
    load(15'h3625, '{8'hdf});
    boot('{8'h03, 8'h36, 8'h25});
    run(15'h3625);
    load(15'h0026, '{8'h32});
    boot('{8'hb8, 8'h26, 8'h02});
    run(15'h0032);
    load(15'h01e6, '{8'h02, 8'h34});
    boot('{8'h04});
    run(15'h0234);
  endtask

  task automatic s_call();
    load(15'h0040, '{8'h06});
    boot('{8'h50, 8'h40, 8'hb8, 8'ha5, 8'hdf});
    run(15'h0004);
    chk8("acc", 8'ha5, acc);
    chk8("stack_lo", 8'h02, mem_u.ram[8'h6f]);
    chk8("stack_hi", 8'h00, mem_u.ram[8'h6e]);
    load(15'h00ff, '{8'hdf});
    boot('{8'h09});
    run(15'h00ff);
    chk8("swi_set", 8'h01, {7'h00, swi});
    load(15'h00ff, '{8'h17, 8'hdf});
    run(15'h0100);
    chk8("swi_clr", 8'h00, {7'h00, swi});
  endtask

  task automatic s_logic();
    boot('{8'h14, 8'hb8, 8'h11, 8'h13, 8'hb8, 8'h22, 8'h13, 8'hc0,
           8'hdf});
    run(15'h0008);
    chk8("acc", 8'h11, acc);
    boot('{8'hb8, 8'h5a, 8'hb0, 8'hff, 8'h11, 8'hdf});
    run(15'h0005);
    chk8("acc", 8'ha5, acc);
    chk8("carry", 8'h01, {7'h00, carry});
    mem_u.ram[8'hf2] = 8'h01;
    boot('{8'h19, 8'h02, 8'hb8, 8'h11, 8'hdf});
    run(15'h0004);
    chk8("acc", 8'h00, acc);
    chk8("reg_f2", 8'h00, mem_u.ram[8'hf2]);
  endtask

  // ==========================================================
  // sequence and hang guard
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      final_report();
    end
  end

  initial begin
    s_imm();
    s_ptr();
    s_table_load_instruction();
    s_jumps();
    s_call();
    s_logic();
    final_report();
  end
endmodule // cpu_addressing_and_flow_tb_top

`default_nettype wire
